// ===== src/prs_pkg.sv
// Purpose: shared constants and types for the power reset sequencer
// Assumes: one system clock at 100 MHz, synchronous active-high reset
// Notes: oscillator pulses are counted as enabled system clock cycles
package prs_pkg;

    // stabilisation wait: 256 x 256 oscillator pulses
    localparam int unsigned OSC_WAIT_BASE = 256;
    localparam int unsigned OSC_WAIT_PULSES = OSC_WAIT_BASE * OSC_WAIT_BASE;

    // program counter start after any power reset
    localparam int PC_WIDTH = 11;
    localparam logic [PC_WIDTH-1:0] RESET_VECTOR = 11'h000;

    // reset level of the release synchroniser stages
    localparam logic SYNC_RESET_LEVEL = 1'b1;

    // outputs of the analog supply monitor
    typedef struct packed {
        logic por_low;      // supply below power-on release level
        logic supply_drop;  // supply below low-voltage detection level
    } prs_monitor_t;

    typedef enum logic [1:0] {
        PRS_CAUSE_NONE,
        PRS_CAUSE_POR,
        PRS_CAUSE_PDR
    } prs_cause_t;

    typedef enum logic [1:0] {
        PRS_ST_RESET,
        PRS_ST_WAIT,
        PRS_ST_RUN
    } prs_state_t;

endpackage

// ===== src/prs_wait_counter.sv
// Purpose: saturating pulse counter for the oscillation stability wait
// Assumes: enable marks one oscillator pulse
// Notes: done stays high until cleared
module prs_wait_counter #(
    parameter int unsigned TERMINAL = prs_pkg::OSC_WAIT_PULSES,
    parameter int unsigned WIDTH = $clog2(TERMINAL + 1)
) (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic reset_in,
    // control
    input wire logic clear_in,
    input wire logic enable_in,
    // status
    output logic [WIDTH-1:0] count_out,
    output logic done_out
);

    logic [WIDTH-1:0] count_q;
    logic [WIDTH-1:0] count_d;

    assign done_out = (count_q == WIDTH'(TERMINAL));
    assign count_out = count_q;

    always_comb begin
        count_d = count_q;
        if (clear_in) begin
            count_d = '0;
        end else if (enable_in && !done_out) begin
            count_d = count_q + WIDTH'(1);
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end

endmodule // prs_wait_counter

// ===== src/prs_reset_sequencer.sv
// Purpose: power-on and power-down reset sequencing for the core
// Assumes: monitor outputs and enable flag synchronous to clk_sys_in
// Notes: reset is forced on the next edge; release waits on sync and count
module prs_reset_sequencer #(
    parameter int unsigned WAIT_PULSES = prs_pkg::OSC_WAIT_PULSES
) (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic reset_in,
    // supply monitor and software flag
    input wire prs_pkg::prs_monitor_t monitor_in,
    input wire logic supply_drop_reset_enable_in,
    // core control
    output logic core_reset_out,
    output logic osc_enable_out,
    output logic wait_active_out,
    output logic pc_load_out,
    output logic [prs_pkg::PC_WIDTH-1:0] pc_value_out,
    output prs_pkg::prs_cause_t reset_cause_out
);

    localparam int unsigned CNT_W = $clog2(WAIT_PULSES + 1);

    prs_pkg::prs_state_t state_q, state_d;
    prs_pkg::prs_cause_t cause_q, cause_d;
    logic pdr_active_q, pdr_active_d;
    logic rel_meta_q, rel_sync_q;
    logic core_reset_q, core_reset_d;
    logic osc_enable_q, osc_enable_d;
    logic wait_active_q, wait_active_d;
    logic pc_load_q, pc_load_d;
    logic [prs_pkg::PC_WIDTH-1:0] pc_value_q;
    logic pdr_request;
    logic raw_reset;
    logic cnt_clear;
    logic cnt_enable;
    logic cnt_done;
    logic [CNT_W-1:0] cnt_value;

    // drop reset latched so that clearing the flag in reset cannot cancel it
    assign pdr_request = pdr_active_q
        || (supply_drop_reset_enable_in && monitor_in.supply_drop);
    assign raw_reset = monitor_in.por_low || pdr_request;

    always_comb begin
        pdr_active_d = monitor_in.supply_drop
            && (pdr_active_q || supply_drop_reset_enable_in);
    end

    // counts only pulses of the running oscillator
    assign cnt_clear = (state_q != prs_pkg::PRS_ST_WAIT);
    assign cnt_enable = osc_enable_q && (state_q == prs_pkg::PRS_ST_WAIT);

    prs_wait_counter #(
        .TERMINAL(WAIT_PULSES),
        .WIDTH(CNT_W)
    ) u_wait (
        .clk_sys_in(clk_sys_in),
        .reset_in(reset_in),
        .clear_in(cnt_clear),
        .enable_in(cnt_enable),
        .count_out(cnt_value),
        .done_out(cnt_done)
    );

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            prs_pkg::PRS_ST_RESET: begin
                // release only once the synchronised reset has fallen
                if (!raw_reset && !rel_sync_q) begin
                    state_d = prs_pkg::PRS_ST_WAIT;
                end
            end
            prs_pkg::PRS_ST_WAIT: begin
                if (cnt_done) begin
                    state_d = prs_pkg::PRS_ST_RUN;
                end
            end
            prs_pkg::PRS_ST_RUN: begin
                state_d = prs_pkg::PRS_ST_RUN;
            end
        endcase
        if (raw_reset) begin
            state_d = prs_pkg::PRS_ST_RESET;
        end
    end

    always_comb begin
        cause_d = cause_q;
        if (monitor_in.por_low) begin
            cause_d = prs_pkg::PRS_CAUSE_POR;
        end else if (pdr_request && state_q != prs_pkg::PRS_ST_RESET) begin
            cause_d = prs_pkg::PRS_CAUSE_PDR;
        end
        osc_enable_d = (state_d != prs_pkg::PRS_ST_RESET);
        core_reset_d = (state_d != prs_pkg::PRS_ST_RUN);
        wait_active_d = (state_d == prs_pkg::PRS_ST_WAIT);
        pc_load_d = (state_q == prs_pkg::PRS_ST_WAIT)
            && (state_d == prs_pkg::PRS_ST_RUN);
    end

    // release synchroniser: first stage feeds the second only
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            rel_meta_q <= prs_pkg::SYNC_RESET_LEVEL;
            rel_sync_q <= prs_pkg::SYNC_RESET_LEVEL;
        end else begin
            rel_meta_q <= raw_reset;
            rel_sync_q <= rel_meta_q;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            state_q <= prs_pkg::PRS_ST_RESET;
            cause_q <= prs_pkg::PRS_CAUSE_NONE;
            pdr_active_q <= 1'b0;
            core_reset_q <= 1'b1;
            osc_enable_q <= 1'b0;
            wait_active_q <= 1'b0;
            pc_load_q <= 1'b0;
            pc_value_q <= prs_pkg::RESET_VECTOR;
        end else begin
            state_q <= state_d;
            cause_q <= cause_d;
            pdr_active_q <= pdr_active_d;
            core_reset_q <= core_reset_d;
            osc_enable_q <= osc_enable_d;
            wait_active_q <= wait_active_d;
            pc_load_q <= pc_load_d;
            pc_value_q <= prs_pkg::RESET_VECTOR;
        end
    end

    assign core_reset_out = core_reset_q;
    assign osc_enable_out = osc_enable_q;
    assign wait_active_out = wait_active_q;
    assign pc_load_out = pc_load_q;
    assign pc_value_out = pc_value_q;
    assign reset_cause_out = cause_q;

    // checks
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (reset_in);

    property p_por_holds_reset;
        monitor_in.por_low |=> core_reset_out && !osc_enable_out;
    endproperty
    a_por_holds_reset: assert property (p_por_holds_reset)
        else $error("core left reset while supply below power-on level");

    property p_osc_halted;
        raw_reset |=> !osc_enable_out && !wait_active_out;
    endproperty
    a_osc_halted: assert property (p_osc_halted)
        else $error("oscillator running during power reset");

    property p_drop_gated;
        (state_q == prs_pkg::PRS_ST_RUN) && !monitor_in.por_low && !pdr_active_q
            && !supply_drop_reset_enable_in |=> !core_reset_out;
    endproperty
    a_drop_gated: assert property (p_drop_gated)
        else $error("drop reset acted with enable flag clear");

    property p_drop_holds;
        pdr_active_q && monitor_in.supply_drop |=> pdr_active_q ##0 core_reset_out;
    endproperty
    a_drop_holds: assert property (p_drop_holds)
        else $error("drop reset released while supply still low");

    property p_run_after_full_wait;
        $rose(pc_load_out) |-> $past(cnt_value) == CNT_W'(WAIT_PULSES);
    endproperty
    a_run_after_full_wait: assert property (p_run_after_full_wait)
        else $error("run entered before stability count reached");

    property p_wait_precedes_run;
        $fell(core_reset_out) |-> $past(wait_active_out) && pc_load_out;
    endproperty
    a_wait_precedes_run: assert property (p_wait_precedes_run)
        else $error("core released without stability wait");

    property p_vector_zero;
        pc_load_out |-> pc_value_out == prs_pkg::RESET_VECTOR && !core_reset_out;
    endproperty
    a_vector_zero: assert property (p_vector_zero)
        else $error("program counter not loaded with zero on release");

    property p_pc_load_pulse;
        pc_load_out |=> !pc_load_out;
    endproperty
    a_pc_load_pulse: assert property (p_pc_load_pulse)
        else $error("program counter load held longer than one cycle");

    // release edge must open the wait on the very next cycle
    property p_release_opens_wait;
        (state_q == prs_pkg::PRS_ST_RESET) && !raw_reset && !rel_sync_q |=> wait_active_out;
    endproperty
    a_release_opens_wait: assert property (p_release_opens_wait)
        else $error("stability wait not started after release");

    property p_por_priority;
        monitor_in.por_low |=> reset_cause_out == prs_pkg::PRS_CAUSE_POR;
    endproperty
    a_por_priority: assert property (p_por_priority)
        else $error("power-on cause not reported");

    property p_sync_release;
        (state_q == prs_pkg::PRS_ST_RESET) && $fell(raw_reset) |->
            !wait_active_out ##1 !wait_active_out;
    endproperty
    a_sync_release: assert property (p_sync_release)
        else $error("wait began before release was synchronised");

    c_por_cycle: cover property ($fell(monitor_in.por_low) ##[1:1000] wait_active_out);
    c_drop_reset: cover property (pdr_active_q ##1 !pdr_active_q ##[1:1000] wait_active_out);
    c_run_reached: cover property (pc_load_out);
    c_por_over_drop: cover property (pdr_active_q && monitor_in.por_low);

endmodule // prs_reset_sequencer

// ===== test/prs_supply_model.sv
// Purpose: supply monitor model facing the reset sequencer
// Assumes: bench sets the supply in millivolts off the rising edge
// Notes: thresholds are typical levels, no hysteresis modelled
module prs_supply_model #(
    parameter int POR_MV = 1500,
    parameter int DROP_MV = 3500
) (
    // supply level from the bench
    input wire integer supply_mv_in,
    // comparator outputs
    output prs_pkg::prs_monitor_t monitor_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // both comparators run from the same level, so a fall to zero shows both
    always_comb begin
        monitor_out.por_low = (supply_mv_in < POR_MV);
        monitor_out.supply_drop = (supply_mv_in < DROP_MV);
    end
endmodule // prs_supply_model

// ===== test/prs_reset_sequencer_tb_top.sv
// Purpose: self-checking bench for the power reset sequencer
// Assumes: wait shortened to 8 pulses to keep the run short
// Notes: inputs change on the falling edge, outputs read there too
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin mismatches++; \
    $display("Error at %0t: got %0h expected %0h", $time, a, b); end end
module prs_reset_sequencer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned WAIT = 8;
    logic clk_sys_in = 1'b0;
    logic reset_in = 1'b1;
    logic drop_enable = 1'b0;
    int supply_mv = 0;
    int mismatches = 0;
    int num_checks = 0;
    int cycles = 0;
    prs_pkg::prs_monitor_t monitor;
    logic core_reset_out;
    logic osc_enable_out;
    logic wait_active_out;
    logic pc_load_out;
    logic [prs_pkg::PC_WIDTH-1:0] pc_value_out;
    prs_pkg::prs_cause_t reset_cause_out;

    always #5 clk_sys_in = ~clk_sys_in;

    prs_supply_model i_supply (
        .supply_mv_in(supply_mv),
        .monitor_out(monitor)
    );

    prs_reset_sequencer #(.WAIT_PULSES(WAIT)) i_dut (
        .clk_sys_in(clk_sys_in),
        .reset_in(reset_in),
        .monitor_in(monitor),
        .supply_drop_reset_enable_in(drop_enable),
        .core_reset_out(core_reset_out),
        .osc_enable_out(osc_enable_out),
        .wait_active_out(wait_active_out),
        .pc_load_out(pc_load_out),
        .pc_value_out(pc_value_out),
        .reset_cause_out(reset_cause_out)
    );

    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // generous ceiling; the whole sequence needs well under 500 cycles
    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            final_report();
        end
    end

    // supply restored or reset_in released just before; counts edges until the core runs
    // lag: one extra edge while the drop latch clears after recovery
    task automatic wait_release(input int lag);
        int n;
        n = 0;
        while (core_reset_out === 1'b1 && n < 100) begin
            @(negedge clk_sys_in);
            n++;
            if (n == 5) begin
                `CHK(({wait_active_out, osc_enable_out}), 2'b11)
            end
        end
        `CHK(n, 3 + lag + WAIT + 1)
        `CHK(pc_load_out, 1'b1)
        `CHK(pc_value_out, prs_pkg::RESET_VECTOR)
        @(negedge clk_sys_in);
        `CHK(({pc_load_out, wait_active_out, core_reset_out}), 3'b000)
    endtask

    // level set, a few edges pass, then the reset state is judged
    task automatic enter_reset(input int mv, input prs_pkg::prs_cause_t cause);
        supply_mv = mv;
        repeat (3) @(negedge clk_sys_in);
        `CHK(({core_reset_out, osc_enable_out}), 2'b10)
        `CHK(reset_cause_out, cause)
    endtask

    task automatic power_on_test();
        enter_reset(0, prs_pkg::PRS_CAUSE_POR);
        supply_mv = 5000;
        wait_release(0);
    endtask

    // mid-run reset returns outputs to reset values, then a normal wait
    task automatic sys_reset_test();
        @(negedge clk_sys_in);
        reset_in = 1'b1;
        repeat (2) @(negedge clk_sys_in);
        `CHK(({core_reset_out, osc_enable_out, wait_active_out, pc_load_out}), 4'b1000)
        `CHK(reset_cause_out, prs_pkg::PRS_CAUSE_NONE)
        reset_in = 1'b0;
        wait_release(0);
    endtask

    // drop ignored while software keeps the flag clear
    task automatic drop_disabled_test();
        drop_enable = 1'b0;
        supply_mv = 3000;
        repeat (20) begin
            @(negedge clk_sys_in);
            `CHK(core_reset_out, 1'b0)
        end
        supply_mv = 5000;
        @(negedge clk_sys_in);
    endtask

    // clearing the flag mid-reset must not cut the reset short
    task automatic drop_enabled_test(input int low_mv);
        drop_enable = 1'b1;
        enter_reset(3000, prs_pkg::PRS_CAUSE_PDR);
        drop_enable = 1'b0;
        supply_mv = low_mv;
        repeat (10) @(negedge clk_sys_in);
        `CHK(core_reset_out, 1'b1)
        supply_mv = 5000;
        wait_release(1);
    endtask

    // fall through to zero during a drop reset hands over to power-on
    task automatic por_priority_test();
        drop_enable = 1'b1;
        enter_reset(3000, prs_pkg::PRS_CAUSE_PDR);
        enter_reset(0, prs_pkg::PRS_CAUSE_POR);
        supply_mv = 5000;
        wait_release(1);
    endtask

    initial begin
        repeat (8) @(negedge clk_sys_in);
        reset_in = 1'b0;
        power_on_test();
        sys_reset_test();
        drop_disabled_test();
        drop_enabled_test(3000);
        drop_enabled_test(2000);
        por_priority_test();
        final_report();
    end
endmodule // prs_reset_sequencer_tb_top
